// file: fshds_source.sv
// Streams the full-speed configuration, interface and endpoint descriptor bytes
// How it works
// - The configuration descriptor opens with length 09h and type 07h and reports total length 0019h.
// - Byte 5 of the configuration descriptor is the configuration value 01h.
// - Byte 6 of the configuration descriptor is string index 00h, meaning no string.
// - Byte 7 is A0h when bus powered and E0h when self powered, never anything else.
// - The attributes byte always sets the remote wake-up bit.
// - Byte 8 carries the bus-powered draw when the power source select is 0, else the self-powered draw.
// - The interface descriptor starts with 09h, 04h, interface 00h and alternate setting 00h.
// - The interface reports one endpoint, class 09h, subclass 00h and protocol 00h.
// - The interface string index is 00h.
// - The endpoint descriptor has length 07h, type 05h and address 81h.
// - The endpoint attributes byte is 03h, interrupt transfer.
// - The endpoint maximum packet size is 0001h.
// - The endpoint polling interval is FFh.
`timescale 1ns/1ps
module fshds_source
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        startReq,
    input  wire logic [15:0] reqLength,
    input  wire logic        cfgLoad,
    input  wire logic        cfgPowerSourceSelect,
    input  wire logic [7:0]  cfgBusPoweredMaxDraw,
    input  wire logic [7:0]  cfgSelfPoweredMaxDraw,
    output logic             busy,
    output logic             byteValid,
    output logic [7:0]       byteData,
    output logic [4:0]       byteIndex,
    output logic             byteLast,
    output logic             powerSourceSelect
);
    typedef struct packed
    {
        fshds_pkg::fshds_fsm_t fsm;
        logic [4:0]            issueIdx;
        logic [4:0]            lastIdx;
        logic                  p1Valid;
        logic [4:0]            p1Idx;
        logic                  p1Last;
        logic                  outValid;
        logic [7:0]            outData;
        logic [4:0]            outIdx;
        logic                  outLast;
        logic                  powerSel;
        logic [7:0]            busDraw;
        logic [7:0]            selfDraw;
    } fshds_state_t;

    fshds_state_t q;
    fshds_state_t d;
    logic [7:0]   romData;

    // Registered lookup costs one stage, so bytes trail a taken start by three cycles
    fshds_rom u_rom
    (
        .core_clk (core_clk),
        .addr     (q.issueIdx),
        .data_q   (romData)
    );

    always_comb
    begin
        d          = q;
        d.p1Valid  = 1'b0;
        d.p1Last   = 1'b0;
        case (q.fsm)
            fshds_pkg::FSHDS_IDLE:
            begin
                // A zero-length request has nothing to send and is dropped
                if (startReq && (reqLength != 16'h0000))
                begin
                    d.fsm      = fshds_pkg::FSHDS_STREAM;
                    d.issueIdx = '0;
                    // Host may ask for fewer bytes than the whole set
                    if (reqLength > fshds_pkg::DESC_TOTAL_LEN)
                        d.lastIdx = fshds_pkg::DESC_LAST_IDX;
                    else
                        d.lastIdx = 5'(reqLength - 16'h0001);
                end
            end
            fshds_pkg::FSHDS_STREAM:
            begin
                d.p1Valid = 1'b1;
                d.p1Idx   = q.issueIdx;
                d.p1Last  = (q.issueIdx == q.lastIdx);
                if (q.issueIdx == q.lastIdx)
                    d.fsm = fshds_pkg::FSHDS_IDLE;
                else
                    d.issueIdx = q.issueIdx + 5'h01;
            end
            default:
            begin
                d.fsm = fshds_pkg::FSHDS_IDLE;
            end
        endcase

        d.outValid = q.p1Valid;
        d.outIdx   = q.p1Idx;
        d.outLast  = q.p1Last;
        // Fixed bytes come from the lookup; only the power-dependent pair is built here
        if (q.p1Idx == fshds_pkg::CFG_ATTR_OFS)
            d.outData = q.powerSel ? fshds_pkg::ATTR_SELF_POWERED : fshds_pkg::ATTR_BUS_POWERED;
        else if (q.p1Idx == fshds_pkg::CFG_MAXPWR_OFS)
            d.outData = q.powerSel ? q.selfDraw : q.busDraw;
        else
            d.outData = romData;

        // A load during a stream takes effect on bytes not yet built
        if (cfgLoad)
        begin
            d.powerSel = cfgPowerSourceSelect;
            d.busDraw  = cfgBusPoweredMaxDraw;
            d.selfDraw = cfgSelfPoweredMaxDraw;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            q          <= '0;
            q.fsm      <= fshds_pkg::FSHDS_IDLE;
            q.powerSel <= fshds_pkg::DEF_POWER_SOURCE;
            q.busDraw  <= fshds_pkg::DEF_BUS_DRAW;
            q.selfDraw <= fshds_pkg::DEF_SELF_DRAW;
        end
        else
        begin
            q <= d;
        end
    end

    assign busy              = (q.fsm == fshds_pkg::FSHDS_STREAM);
    assign byteValid         = q.outValid;
    assign byteData          = q.outData;
    assign byteIndex         = q.outIdx;
    assign byteLast          = q.outLast;
    assign powerSourceSelect = q.powerSel;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence sStartTaken;
        (q.fsm == fshds_pkg::FSHDS_IDLE) && startReq && (reqLength != 16'h0000);
    endsequence

    sequence sFirstByte;
        byteValid && (byteIndex == 5'h00) && (byteData == fshds_pkg::CFG_LEN);
    endsequence

    sequence sBusyRun;
        busy [*2];
    endsequence

    first_byte_latency_a: assert property (sStartTaken |-> ##3 sFirstByte)
        else $error("first byte not at offset 0 three cycles after start");

    stream_busy_a: assert property (sStartTaken |=> busy)
        else $error("stream did not start after request");

    stream_busy_run_a: assert property ((sStartTaken ##0 (reqLength != 16'h0001)) |=> sBusyRun)
        else $error("stream shorter than two issue cycles");

    ascending_order_a: assert property (byteValid && !byteLast |=>
                                        byteValid && (byteIndex == $past(byteIndex) + 5'h01))
        else $error("bytes not sent in ascending order");

    stream_gap_a: assert property (byteLast |=> !byteValid)
        else $error("no idle cycle after the last byte");

    cfg_header_a: assert property (byteValid && (byteIndex <= fshds_pkg::CFG_TOTHI_OFS) |->
                                   byteData == ((byteIndex == 5'h00) ? fshds_pkg::CFG_LEN :
                                                (byteIndex == 5'h01) ? fshds_pkg::CFG_TYPE :
                                                (byteIndex == 5'h02) ? 8'h19 : 8'h00))
        else $error("configuration header byte wrong");

    cfg_value_str_a: assert property (byteValid && (byteIndex == fshds_pkg::CFG_VALUE_OFS) |->
                                      (byteData == 8'h01) ##1 (!byteValid || (byteData == 8'h00)))
        else $error("configuration value or string index wrong");

    attr_power_a: assert property (byteValid && (byteIndex == fshds_pkg::CFG_ATTR_OFS) |->
                                   byteData == ($past(q.powerSel) ? 8'he0 : 8'ha0))
        else $error("attributes do not follow power source");

    attr_legal_a: assert property (byteValid && (byteIndex == fshds_pkg::CFG_ATTR_OFS) |->
                                   byteData inside {8'ha0, 8'he0})
        else $error("reserved attributes value reported");

    remote_wake_a: assert property (byteValid && (byteIndex == fshds_pkg::CFG_ATTR_OFS) |->
                                    byteData[fshds_pkg::REMOTE_WAKE_BIT])
        else $error("remote wake-up not advertised");

    max_power_a: assert property (byteValid && (byteIndex == fshds_pkg::CFG_MAXPWR_OFS) |->
                                  byteData == ($past(q.powerSel) ? $past(q.selfDraw) : $past(q.busDraw)))
        else $error("max power byte from wrong field");

    draw_load_a: assert property (cfgLoad |=> (q.busDraw == $past(cfgBusPoweredMaxDraw)) &&
                                  (q.selfDraw == $past(cfgSelfPoweredMaxDraw)))
        else $error("configuration load not taken");

    select_load_a: assert property (cfgLoad |=> powerSourceSelect == $past(cfgPowerSourceSelect))
        else $error("power source select not taken");

    if_bytes_a: assert property (byteValid && (byteIndex >= fshds_pkg::IF_BASE) &&
                                 (byteIndex < fshds_pkg::EP_BASE) |->
                                 byteData == ((byteIndex == 5'h09) ? 8'h09 : (byteIndex == 5'h0a) ? 8'h04 :
                                              (byteIndex == 5'h0d) ? 8'h01 : (byteIndex == 5'h0e) ? 8'h09 :
                                              8'h00))
        else $error("interface descriptor byte wrong");

    ep_bytes_a: assert property (byteValid && (byteIndex >= fshds_pkg::EP_BASE) |->
                                 byteData == ((byteIndex == 5'h12) ? 8'h07 : (byteIndex == 5'h13) ? 8'h05 :
                                              (byteIndex == 5'h14) ? 8'h81 : (byteIndex == 5'h15) ? 8'h03 :
                                              (byteIndex == 5'h16) ? 8'h01 : (byteIndex == 5'h17) ? 8'h00 :
                                              8'hff))
        else $error("endpoint descriptor byte wrong");
endmodule : fshds_source

// file: fshds_pkg.sv
// Constants and types shared by the full-speed hub descriptor source
package fshds_pkg;
    localparam int unsigned IDX_W = 5;
    localparam logic [IDX_W-1:0] DESC_LAST_IDX = 5'h18;
    localparam logic [15:0] DESC_TOTAL_LEN = 16'h0019;
    localparam logic [IDX_W-1:0] CFG_LEN_OFS = 5'h00;
    localparam logic [IDX_W-1:0] CFG_TYPE_OFS = 5'h01;
    localparam logic [IDX_W-1:0] CFG_TOTLO_OFS = 5'h02;
    localparam logic [IDX_W-1:0] CFG_TOTHI_OFS = 5'h03;
    localparam logic [IDX_W-1:0] CFG_NUMIF_OFS = 5'h04;
    localparam logic [IDX_W-1:0] CFG_VALUE_OFS = 5'h05;
    localparam logic [IDX_W-1:0] CFG_STR_OFS = 5'h06;
    localparam logic [IDX_W-1:0] CFG_ATTR_OFS = 5'h07;
    localparam logic [IDX_W-1:0] CFG_MAXPWR_OFS = 5'h08;
    localparam logic [IDX_W-1:0] IF_BASE = 5'h09;
    localparam logic [IDX_W-1:0] EP_BASE = 5'h12;
    localparam logic [IDX_W-1:0] EP_MPS_LO_OFS = 5'h16;
    localparam logic [IDX_W-1:0] EP_MPS_HI_OFS = 5'h17;
    localparam logic [IDX_W-1:0] EP_INTERVAL_OFS = 5'h18;
    localparam int unsigned REMOTE_WAKE_BIT = 5;
    localparam logic [7:0] CFG_LEN = 8'h09;
    localparam logic [7:0] CFG_TYPE = 8'h07;
    localparam logic [7:0] CFG_NUMIF = 8'h01;
    localparam logic [7:0] CFG_VALUE = 8'h01;
    localparam logic [7:0] CFG_STR = 8'h00;
    localparam logic [7:0] ATTR_BUS_POWERED = 8'ha0;
    localparam logic [7:0] ATTR_SELF_POWERED = 8'he0;
    localparam logic [7:0] IF_LEN = 8'h09;
    localparam logic [7:0] IF_TYPE = 8'h04;
    localparam logic [7:0] IF_NUMBER = 8'h00;
    localparam logic [7:0] IF_ALT = 8'h00;
    localparam logic [7:0] IF_NUM_EP = 8'h01;
    localparam logic [7:0] IF_CLASS = 8'h09;
    localparam logic [7:0] IF_SUBCLASS = 8'h00;
    localparam logic [7:0] IF_PROTOCOL = 8'h00;
    localparam logic [7:0] IF_STR = 8'h00;
    localparam logic [7:0] EP_LEN = 8'h07;
    localparam logic [7:0] EP_TYPE = 8'h05;
    localparam logic [7:0] EP_ADDR = 8'h81;
    localparam logic [7:0] EP_ATTR = 8'h03;
    localparam logic [15:0] EP_MPS = 16'h0001;
    localparam logic [7:0] EP_INTERVAL = 8'hff;
    localparam logic [7:0] FILL_BYTE = 8'h00;
    localparam logic DEF_POWER_SOURCE = 1'b0;
    localparam logic [7:0] DEF_BUS_DRAW = 8'h32;
    localparam logic [7:0] DEF_SELF_DRAW = 8'h01;
    localparam int unsigned START_TO_FIRST = 3;

    typedef enum logic [1:0]
    {
        FSHDS_IDLE   = 2'b01,
        FSHDS_STREAM = 2'b10
    } fshds_fsm_t;
endpackage : fshds_pkg

// file: fshds_rom.sv
// Registered lookup of the fixed descriptor bytes
`timescale 1ns/1ps
module fshds_rom
(
    input  wire logic                       core_clk,
    input  wire logic [fshds_pkg::IDX_W-1:0] addr,
    output logic      [7:0]                 data_q
);
    typedef struct packed
    {
        logic [7:0] data;
    } fshds_rom_state_t;

    fshds_rom_state_t q;
    fshds_rom_state_t d;

    function automatic logic [7:0] fshdsFixedByte(input logic [fshds_pkg::IDX_W-1:0] idx);
        case (idx)
            5'h00:   fshdsFixedByte = fshds_pkg::CFG_LEN;
            5'h01:   fshdsFixedByte = fshds_pkg::CFG_TYPE;
            5'h02:   fshdsFixedByte = fshds_pkg::DESC_TOTAL_LEN[7:0];
            5'h03:   fshdsFixedByte = fshds_pkg::DESC_TOTAL_LEN[15:8];
            5'h04:   fshdsFixedByte = fshds_pkg::CFG_NUMIF;
            5'h05:   fshdsFixedByte = fshds_pkg::CFG_VALUE;
            5'h06:   fshdsFixedByte = fshds_pkg::CFG_STR;
            5'h09:   fshdsFixedByte = fshds_pkg::IF_LEN;
            5'h0a:   fshdsFixedByte = fshds_pkg::IF_TYPE;
            5'h0b:   fshdsFixedByte = fshds_pkg::IF_NUMBER;
            5'h0c:   fshdsFixedByte = fshds_pkg::IF_ALT;
            5'h0d:   fshdsFixedByte = fshds_pkg::IF_NUM_EP;
            5'h0e:   fshdsFixedByte = fshds_pkg::IF_CLASS;
            5'h0f:   fshdsFixedByte = fshds_pkg::IF_SUBCLASS;
            5'h10:   fshdsFixedByte = fshds_pkg::IF_PROTOCOL;
            5'h11:   fshdsFixedByte = fshds_pkg::IF_STR;
            5'h12:   fshdsFixedByte = fshds_pkg::EP_LEN;
            5'h13:   fshdsFixedByte = fshds_pkg::EP_TYPE;
            5'h14:   fshdsFixedByte = fshds_pkg::EP_ADDR;
            5'h15:   fshdsFixedByte = fshds_pkg::EP_ATTR;
            5'h16:   fshdsFixedByte = fshds_pkg::EP_MPS[7:0];
            5'h17:   fshdsFixedByte = fshds_pkg::EP_MPS[15:8];
            5'h18:   fshdsFixedByte = fshds_pkg::EP_INTERVAL;
            default: fshdsFixedByte = fshds_pkg::FILL_BYTE;
        endcase
    endfunction : fshdsFixedByte

    always_comb
    begin
        d      = q;
        d.data = fshdsFixedByte(addr);
    end

    always_ff @(posedge core_clk)
    begin
        q <= d;
    end

    assign data_q = q.data;
endmodule : fshds_rom

// file: fshds_host_model.sv
// Host-side reader that starts descriptor reads and logs every returned byte
`timescale 1ns/1ps
module fshds_host_model
(
    input  wire logic       core_clk,
    output logic            startReq,
    output logic [15:0]     reqLength,
    input  wire logic       byteValid,
    input  wire logic [7:0] byteData,
    input  wire logic [4:0] byteIndex,
    input  wire logic       byteLast
);
    int          cyc = 0;
    int          takeCyc = 0;
    logic [13:0] rxQ[$];
    int          rxCyc[$];

    initial
    begin
        startReq  = 1'b0;
        reqLength = 16'hffff;
    end

    // Released length shows the inverse so a stale value is never trusted
    task automatic request(input logic [15:0] len);
        @(negedge core_clk);
        startReq  = 1'b1;
        reqLength = len;
        @(negedge core_clk);
        startReq  = 1'b0;
        reqLength = ~len;
    endtask : request

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (startReq)
            takeCyc <= cyc;
        if (byteValid)
        begin
            rxQ.push_back({byteLast, byteIndex, byteData});
            rxCyc.push_back(cyc);
        end
    end
endmodule : fshds_host_model

// file: tb.sv
// Self-checking bench for the full-speed hub descriptor source
`timescale 1ns/1ps
`define CHK(g, e) check(16'(g), 16'(e))
module tb;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        startReq;
    logic [15:0] reqLength;
    logic        cfgLoad = 1'b0;
    logic        cfgPowerSourceSelect = 1'b0;
    logic [7:0]  cfgBusPoweredMaxDraw = 8'h00;
    logic [7:0]  cfgSelfPoweredMaxDraw = 8'h00;
    logic        busy;
    logic        byteValid;
    logic [7:0]  byteData;
    logic [4:0]  byteIndex;
    logic        byteLast;
    logic        powerSourceSelect;
    int          errCount = 0;
    int          compares = 0;
    int          seed = 70067;
    int          pss = 0;
    int          bp = 'h32;
    int          sp = 'h01;
    int          tbl[25] = '{'h09, 'h07, 'h19, 'h00, 'h01, 'h01, 'h00, 0, 0, 'h09, 'h04, 'h00, 'h00,
                             'h01, 'h09, 'h00, 'h00, 'h00, 'h07, 'h05, 'h81, 'h03, 'h01, 'h00, 'hff};

    always #5 core_clk = ~core_clk;

    fshds_source u_dut (.core_clk(core_clk), .rst_n(rst_n), .startReq(startReq), .reqLength(reqLength),
        .cfgLoad(cfgLoad), .cfgPowerSourceSelect(cfgPowerSourceSelect),
        .cfgBusPoweredMaxDraw(cfgBusPoweredMaxDraw), .cfgSelfPoweredMaxDraw(cfgSelfPoweredMaxDraw),
        .busy(busy), .byteValid(byteValid), .byteData(byteData), .byteIndex(byteIndex),
        .byteLast(byteLast), .powerSourceSelect(powerSourceSelect));

    fshds_host_model u_host (.core_clk(core_clk), .startReq(startReq), .reqLength(reqLength),
        .byteValid(byteValid), .byteData(byteData), .byteIndex(byteIndex), .byteLast(byteLast));

    task automatic check(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            errCount++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : check

    task automatic wrapUp;
        $display("compares %0d mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrapUp

    function automatic int expByte(input int i);
        if (i == 7)
            return pss ? 'he0 : 'ha0;
        if (i == 8)
            return pss ? sp : bp;
        return tbl[i];
    endfunction : expByte

    task automatic load(input int p, input int b, input int s);
        @(negedge core_clk);
        cfgLoad = 1'b1;
        cfgPowerSourceSelect = p[0];
        cfgBusPoweredMaxDraw = b[7:0];
        cfgSelfPoweredMaxDraw = s[7:0];
        @(negedge core_clk);
        cfgLoad = 1'b0;
        pss = p & 1;
        bp = b & 'hff;
        sp = s & 'hff;
        `CHK(powerSourceSelect, pss);
    endtask : load

    // Reads len bytes, at most 25, and compares order, values, pairing and spacing
    task automatic stream(input int len);
        int n;
        int t0;
        int i;
        n = (len == 0) ? 0 : ((len > 25) ? 25 : len);
        u_host.rxQ.delete();
        u_host.rxCyc.delete();
        u_host.request(len[15:0]);
        t0 = u_host.takeCyc;
        `CHK(busy, n > 0);
        for (i = 0; i < 60 && u_host.rxQ.size() < n; i++)
            @(posedge core_clk);
        if (u_host.rxQ.size() < n)
        begin
            errCount++;
            $display("unexpected at %0t: got %h exp %h", $time, u_host.rxQ.size(), n);
            wrapUp();
        end
        repeat (8) @(negedge core_clk);
        `CHK(u_host.rxQ.size(), n);
        `CHK(busy, 0);
        `CHK(byteValid, 0);
        if (n > 0)
            `CHK(u_host.rxCyc[0] - t0, fshds_pkg::START_TO_FIRST);
        for (i = 0; i < n; i++)
        begin
            `CHK(u_host.rxQ[i], {i == n - 1, 5'(i), 8'(expByte(i))});
            `CHK(u_host.rxCyc[i], u_host.rxCyc[0] + i);
        end
        $display("test stream length %0d done", len);
    endtask : stream

    initial
    begin
        repeat (20000) @(posedge core_clk);
        errCount++;
        wrapUp();
    end

    initial
    begin
        int k;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        `CHK(busy, 0);
        `CHK(powerSourceSelect, 0);
        stream(25);
        load(1, $random(seed), $random(seed));
        stream(300);
        stream(0);
        fork
            stream(25);
            begin
                repeat (6) @(negedge core_clk);
                u_host.request(16'h0005);
            end
        join
        for (k = 0; k < 12; k++)
        begin
            load($random(seed), $random(seed), $random(seed));
            stream($random(seed) & 31);
        end
        load(0, 'hc8, 'h02);
        stream(9);
        // Reset in mid-stream must drop the stream and bring back the load defaults
        load(1, 'h11, 'h22);
        u_host.request(16'h0019);
        repeat (5) @(negedge core_clk);
        rst_n = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        pss = fshds_pkg::DEF_POWER_SOURCE;
        bp = fshds_pkg::DEF_BUS_DRAW;
        sp = fshds_pkg::DEF_SELF_DRAW;
        `CHK(busy, 0);
        `CHK(byteValid, 0);
        `CHK(byteLast, 0);
        `CHK(byteIndex, 0);
        `CHK(powerSourceSelect, pss);
        stream(9);
        wrapUp();
    end
endmodule : tb
